/* File: fsled_pkg.sv */
// shared constants and types of the fieldbus status indicator encoder
package fsled_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS     = 10;
  localparam int unsigned FLASH_HALF_MS     = 500;
  localparam int unsigned FLASH_HALF_CYCLES = FLASH_HALF_MS * 1000000 / CLK_PERIOD_NS;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam int unsigned ADDR_W      = 5;
  localparam logic [4:0]  OFF_CTRL    = 5'h00;
  localparam logic [4:0]  OFF_STATUS  = 5'h04;
  localparam logic [4:0]  OFF_IRQ_ST  = 5'h08;
  localparam logic [4:0]  OFF_IRQ_CLR = 5'h0C;
  localparam logic [4:0]  OFF_IRQ_EN  = 5'h10;

  localparam int unsigned CTRL_EN_BIT  = 0;
  localparam logic        CTRL_EN_RST  = 1'h1;
  localparam int unsigned STAT_MOD_LSB = 0;
  localparam int unsigned STAT_NET_LSB = 8;
  localparam int unsigned STAT_PH_BIT  = 16;

  localparam int unsigned IRQ_W        = 3;
  localparam int unsigned IRQ_MOD_BIT  = 0;
  localparam int unsigned IRQ_NET_BIT  = 1;
  localparam int unsigned IRQ_CRIT_BIT = 2;
  localparam logic [2:0]  IRQ_EN_RST   = 3'h0;

  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [5:0] {
    FSLED_OFF         = 6'h01,
    FSLED_SOLID_GREEN = 6'h02,
    FSLED_FLASH_GREEN = 6'h04,
    FSLED_FLASH_RED   = 6'h08,
    FSLED_SOLID_RED   = 6'h10,
    FSLED_FLASH_ALT   = 6'h20
  } fsled_mode_type;

  typedef struct packed {
    logic self_test;
    logic unrecoverable;
    logic minor_fault;
    logic standby;
    logic operational;
  } fsled_health_type;

  typedef struct packed {
    logic dup_mac_done;
    logic connected;
    logic io_timeout;
    logic dup_mac_fail;
    logic bus_off;
    logic comm_faulted;
    logic identify_long;
  } fsled_net_type;

  typedef struct packed {
    logic green;
    logic red;
  } fsled_led_type;

  typedef struct packed {
    logic [4:0]  awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [4:0]  araddr;
    logic        arvalid;
    logic        rready;
  } fsled_axi_req_type;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } fsled_axi_rsp_type;

endpackage : fsled_pkg

/* File: fsled_flash_timebase.sv */
// shared flash phase toggle for all flashing and alternating indicator patterns
`timescale 1ns/10ps
module fsled_flash_timebase #(
  parameter int unsigned HALF = 50000000
) (
  input  wire logic clk,
  input  wire logic rst,
  output logic      phase
);
  import fsled_pkg::*;

  typedef struct packed {
    logic [31:0] cnt;
    logic        phase;
  } fsled_tb_state_type;

  fsled_tb_state_type q;
  fsled_tb_state_type d;

  always_comb begin
    d = q;
    if (q.cnt == 32'(HALF - 1)) begin
      d.cnt   = 32'h0;
      d.phase = !q.phase;
    end else begin
      d.cnt = q.cnt + 32'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign phase = q.phase;

  // a toggle only ever follows a full count, never a partial one
  a_phase_period: assert property (@(posedge clk) disable iff (rst)
    $changed(q.phase) |-> (q.cnt == 32'h0 && $past(q.cnt) == 32'(HALF - 1)))
    else $error("flash phase toggled off its count");

endmodule : fsled_flash_timebase

/* File: fsled_led_drive.sv */
// one bi-colour indicator: display mode to registered green and red drives
`timescale 1ns/10ps
module fsled_led_drive (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire fsled_pkg::fsled_mode_type mode,
  input  wire logic                      phase,
  input  wire logic                      enable,
  output fsled_pkg::fsled_led_type       led
);
  import fsled_pkg::*;

  fsled_led_type q;
  fsled_led_type d;

  always_comb begin
    d = '0;
    if (enable) begin
      unique case (mode)
        FSLED_OFF:         d = '0;
        FSLED_SOLID_GREEN: d.green = 1'b1;
        FSLED_FLASH_GREEN: d.green = phase;
        FSLED_FLASH_RED:   d.red = phase;
        FSLED_SOLID_RED:   d.red = 1'b1;
        FSLED_FLASH_ALT: begin
          // complementary halves: never both colours at once
          d.green = phase;
          d.red   = !phase;
        end
        default:           d = '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign led = q;

  a_alt_exclusive: assert property (@(posedge clk) disable iff (rst)
    !(q.green && q.red))
    else $error("red and green lit together");

  a_flash_follows: assert property (@(posedge clk) disable iff (rst)
    (enable && mode == FSLED_FLASH_ALT) |=> (q.green == $past(phase) && q.red != $past(phase)))
    else $error("alternating pattern off the shared phase");

endmodule : fsled_led_drive

/* File: fsled_encoder_top.sv */
// fieldbus node status indicators: state encoding, AXI4-Lite registers, interrupt
`timescale 1ns/10ps
// Behaviour
// - two independent bi-colour indicators: health, network
// - normal operation: health indicator steady green
// - standby needing commissioning: health flashes green
// - minor fault flashes red; unrecoverable steady red
// - self-test: health flashes red and green alternately
// - before duplicate-address test passes: network off
// - on-line without connection: network flashes green
// - connection established or allocated: network steady green
// - any I/O connection timed out: flash red
// - duplicate address or bus-off: steady red
// - comm-faulted plus long identify: alternate red/green
module fsled_encoder_top #(
  parameter int unsigned FLASH_HALF = fsled_pkg::FLASH_HALF_CYCLES
) (
  input  wire logic                         clk,
  input  wire logic                         rst,
  input  wire fsled_pkg::fsled_health_type  health,
  input  wire fsled_pkg::fsled_net_type     net,
  input  wire fsled_pkg::fsled_axi_req_type axi_req,
  output fsled_pkg::fsled_axi_rsp_type      axi_rsp,
  output fsled_pkg::fsled_led_type          module_led,
  output fsled_pkg::fsled_led_type          net_led,
  output logic                              irq
);
  import fsled_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    fsled_mode_type     mod_mode;
    fsled_mode_type     net_mode;
    logic               aw_have;
    logic [ADDR_W-1:0]  aw_addr;
    logic               w_have;
    logic [31:0]        w_data;
    logic [3:0]         w_strb;
    logic               awready;
    logic               wready;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               arready;
    logic               rvalid;
    logic [31:0]        rdata;
    logic [1:0]         rresp;
    logic               ctrl_en;
    logic [IRQ_W-1:0]   irq_stat;
    logic [IRQ_W-1:0]   irq_en;
    logic               irq;
  } fsled_top_state_type;

  localparam fsled_top_state_type RST_STATE = '{
    mod_mode: FSLED_OFF,
    net_mode: FSLED_OFF,
    aw_have:  1'b0,
    aw_addr:  '0,
    w_have:   1'b0,
    w_data:   32'h0,
    w_strb:   4'h0,
    awready:  1'b0,
    wready:   1'b0,
    bvalid:   1'b0,
    bresp:    RESP_OKAY,
    arready:  1'b0,
    rvalid:   1'b0,
    rdata:    32'h0,
    rresp:    RESP_OKAY,
    ctrl_en:  CTRL_EN_RST,
    irq_stat: '0,
    irq_en:   IRQ_EN_RST,
    irq:      1'b0
  };

  fsled_top_state_type q;
  fsled_top_state_type d;
  logic                phase;
  logic                crit;

  // ****************************************************************
  // shared flash timebase and the two indicator drivers
  // ****************************************************************
  fsled_flash_timebase #(
    .HALF (FLASH_HALF)
  ) u_timebase (
    .clk   (clk),
    .rst   (rst),
    .phase (phase)
  );

  // both drivers read the same phase so flashes stay aligned
  fsled_led_drive u_module_drive (
    .clk    (clk),
    .rst    (rst),
    .mode   (q.mod_mode),
    .phase  (phase),
    .enable (q.ctrl_en),
    .led    (module_led)
  );

  fsled_led_drive u_net_drive (
    .clk    (clk),
    .rst    (rst),
    .mode   (q.net_mode),
    .phase  (phase),
    .enable (q.ctrl_en),
    .led    (net_led)
  );

  assign crit = net.dup_mac_fail || net.bus_off;

  // ****************************************************************
  // register read mux
  // ****************************************************************
  function automatic logic [31:0] read_word(
    input logic [ADDR_W-1:0] addr,
    input fsled_top_state_type s,
    input logic ph
  );
    logic [31:0] w;
    w = 32'h0;
    case (addr)
      OFF_CTRL:    w[CTRL_EN_BIT] = s.ctrl_en;
      OFF_STATUS: begin
        w[STAT_MOD_LSB +: 6] = s.mod_mode;
        w[STAT_NET_LSB +: 6] = s.net_mode;
        w[STAT_PH_BIT]       = ph;
      end
      OFF_IRQ_ST:  w[IRQ_W-1:0] = s.irq_stat;
      OFF_IRQ_EN:  w[IRQ_W-1:0] = s.irq_en;
      default:     w = 32'h0;
    endcase
    return w;
  endfunction : read_word

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    logic [IRQ_W-1:0] ev;
    logic [IRQ_W-1:0] clr;
    ev  = '0;
    clr = '0;
    d   = q;

    // health: self-test over faults over standby over normal
    if (health.self_test) begin
      d.mod_mode = FSLED_FLASH_ALT;
    end else if (health.unrecoverable) begin
      d.mod_mode = FSLED_SOLID_RED;
    end else if (health.minor_fault) begin
      d.mod_mode = FSLED_FLASH_RED;
    end else if (health.standby) begin
      d.mod_mode = FSLED_FLASH_GREEN;
    end else if (health.operational) begin
      d.mod_mode = FSLED_SOLID_GREEN;
    end else begin
      d.mod_mode = FSLED_OFF;
    end

    // network: most severe condition first
    if (crit) begin
      d.net_mode = FSLED_SOLID_RED;
    end else if (net.comm_faulted) begin
      // faulted but not yet identified still cannot talk: steady red
      d.net_mode = net.identify_long ? FSLED_FLASH_ALT : FSLED_SOLID_RED;
    end else if (net.io_timeout) begin
      d.net_mode = FSLED_FLASH_RED;
    end else if (!net.dup_mac_done) begin
      d.net_mode = FSLED_OFF;
    end else if (net.connected) begin
      d.net_mode = FSLED_SOLID_GREEN;
    end else begin
      d.net_mode = FSLED_FLASH_GREEN;
    end

    ev[IRQ_MOD_BIT]  = d.mod_mode != q.mod_mode;
    ev[IRQ_NET_BIT]  = d.net_mode != q.net_mode;
    ev[IRQ_CRIT_BIT] = d.net_mode == FSLED_SOLID_RED && q.net_mode != FSLED_SOLID_RED;

    // write channel: address and data taken in either order
    if (axi_req.awvalid && q.awready) begin
      d.aw_have = 1'b1;
      d.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && q.wready) begin
      d.w_have = 1'b1;
      d.w_data = axi_req.wdata;
      d.w_strb = axi_req.wstrb;
    end
    if (q.bvalid && axi_req.bready) begin
      d.bvalid = 1'b0;
    end
    if (d.aw_have && d.w_have && !d.bvalid) begin
      d.aw_have = 1'b0;
      d.w_have  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = RESP_OKAY;
      case (d.aw_addr)
        OFF_CTRL: begin
          if (d.w_strb[0]) begin
            d.ctrl_en = d.w_data[CTRL_EN_BIT];
          end
        end
        OFF_IRQ_CLR: begin
          if (d.w_strb[0]) begin
            clr = d.w_data[IRQ_W-1:0];
          end
        end
        OFF_IRQ_EN: begin
          if (d.w_strb[0]) begin
            d.irq_en = d.w_data[IRQ_W-1:0];
          end
        end
        default: d.bresp = RESP_SLVERR;
      endcase
    end
    d.awready = !d.aw_have && !d.bvalid;
    d.wready  = !d.w_have && !d.bvalid;

    // read channel: one read in flight, answered the next cycle
    if (q.rvalid && axi_req.rready) begin
      d.rvalid = 1'b0;
    end
    if (axi_req.arvalid && q.arready) begin
      d.rvalid = 1'b1;
      d.rdata  = read_word(axi_req.araddr, q, phase);
      unique case (axi_req.araddr)
        OFF_CTRL, OFF_STATUS, OFF_IRQ_ST, OFF_IRQ_CLR, OFF_IRQ_EN: d.rresp = RESP_OKAY;
        default: d.rresp = RESP_SLVERR;
      endcase
    end
    d.arready = !d.rvalid;

    // a new event outranks a clear landing in the same cycle
    d.irq_stat = (q.irq_stat & ~clr) | ev;
    d.irq      = |(d.irq_stat & d.irq_en);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= RST_STATE;
    end else begin
      q <= d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign axi_rsp.awready = q.awready;
  assign axi_rsp.wready  = q.wready;
  assign axi_rsp.bresp   = q.bresp;
  assign axi_rsp.bvalid  = q.bvalid;
  assign axi_rsp.arready = q.arready;
  assign axi_rsp.rdata   = q.rdata;
  assign axi_rsp.rresp   = q.rresp;
  assign axi_rsp.rvalid  = q.rvalid;
  assign irq             = q.irq;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // the drive stage reads the enable one edge late, so the pin check uses the previous enable
  a_mod_normal: assert property (
    (health == 5'h01) |=> (q.mod_mode == FSLED_SOLID_GREEN) ##1 (!$past(q.ctrl_en) || module_led.green))
    else $error("normal health not steady green");

  a_mod_standby: assert property (
    (health[4:1] == 4'h1) |=> (q.mod_mode == FSLED_FLASH_GREEN))
    else $error("standby not flashing green");

  a_mod_fault: assert property (
    (!health.self_test && (health.unrecoverable || health.minor_fault))
    |=> (q.mod_mode == (($past(health.unrecoverable)) ? FSLED_SOLID_RED : FSLED_FLASH_RED)))
    else $error("fault pattern wrong");

  a_mod_selftest: assert property (
    health.self_test |=> (q.mod_mode == FSLED_FLASH_ALT))
    else $error("self-test not alternating");

  a_net_offline: assert property (
    (!crit && !net.comm_faulted && !net.io_timeout && !net.dup_mac_done)
    |=> (q.net_mode == FSLED_OFF) ##1 (net_led == '0))
    else $error("off-line network indicator lit");

  a_net_unconn: assert property (
    (!crit && !net.comm_faulted && !net.io_timeout && net.dup_mac_done && !net.connected)
    |=> (q.net_mode == FSLED_FLASH_GREEN))
    else $error("unconnected not flashing green");

  a_net_conn: assert property (
    (!crit && !net.comm_faulted && !net.io_timeout && net.dup_mac_done && net.connected)
    |=> (q.net_mode == FSLED_SOLID_GREEN))
    else $error("connected not steady green");

  a_net_timeout: assert property (
    (!crit && !net.comm_faulted && net.io_timeout) |=> (q.net_mode == FSLED_FLASH_RED))
    else $error("timeout not flashing red");

  a_net_critical: assert property (
    crit |=> (q.net_mode == FSLED_SOLID_RED) ##1 (!$past(q.ctrl_en) || (net_led.red && !net_led.green)))
    else $error("critical failure not steady red");

  a_net_identify: assert property (
    (!crit && net.comm_faulted && net.identify_long) |=> (q.net_mode == FSLED_FLASH_ALT))
    else $error("identified fault not alternating");

  a_net_severity: assert property (
    (crit && net.comm_faulted && net.identify_long && net.io_timeout && net.connected)
    |=> (q.net_mode == FSLED_SOLID_RED))
    else $error("severity order broken");

  a_led_disable: assert property (
    !q.ctrl_en |=> (module_led == '0 && net_led == '0))
    else $error("indicators lit while disabled");

  a_irq_sticky: assert property (
    (q.net_mode != $past(q.net_mode)) |-> q.irq_stat[IRQ_NET_BIT])
    else $error("network change not latched");

  a_bresp_hold: assert property (
    (q.bvalid && !axi_req.bready) |=> (q.bvalid && $stable(q.bresp)))
    else $error("write response dropped early");

  a_rdata_hold: assert property (
    (q.rvalid && !axi_req.rready) |=> (q.rvalid && $stable(q.rdata) && $stable(q.rresp)))
    else $error("read answer dropped early");

  a_crit_event: assert property (
    (crit && q.net_mode != FSLED_SOLID_RED) |=> q.irq_stat[IRQ_CRIT_BIT])
    else $error("critical failure not latched");

  a_health_event: assert property (
    (q.mod_mode != $past(q.mod_mode)) |-> q.irq_stat[IRQ_MOD_BIT])
    else $error("health change not latched");

endmodule : fsled_encoder_top

/* File: fsled_observer.sv */
// operator model: watches both indicators for one flash period and names each pattern
`timescale 1ns/10ps
module fsled_observer #(
  parameter int unsigned HALF = 4
) (
  input  wire logic                     clk,
  input  wire fsled_pkg::fsled_led_type module_led,
  input  wire fsled_pkg::fsled_led_type net_led,
  input  wire logic                     start,
  output logic                          valid,
  output logic [5:0]                    hmode,
  output logic [5:0]                    nmode,
  output logic [3:0]                    skew
);
  import fsled_pkg::*;
  localparam int unsigned N = 2 * HALF;
  int unsigned cnt, hg, hr, hb, ng, nr, nb, sk;
  logic        run = 1'b0;
  initial valid = 1'b0;

  // any window of one full period holds exactly HALF lit cycles of a flash, whatever its phase
  function automatic logic [5:0] name_of(int unsigned g, int unsigned r, int unsigned b);
    if (g == 0 && r == 0) return 6'h01;
    if (g == N && r == 0) return 6'h02;
    if (g == HALF && r == 0) return 6'h04;
    if (r == HALF && g == 0) return 6'h08;
    if (r == N && g == 0) return 6'h10;
    if (g == HALF && r == HALF && b == 0) return 6'h20;
    return 6'h00;
  endfunction : name_of

  always @(posedge clk) begin
    valid <= run && cnt == N - 1;
    if (start) begin
      {cnt, hg, hr, hb, ng, nr, nb, sk} <= '0;
      run <= 1'b1;
    end else if (run) begin
      hg  <= hg + module_led.green;
      hr  <= hr + module_led.red;
      hb  <= hb + (module_led.green & module_led.red);
      ng  <= ng + net_led.green;
      nr  <= nr + net_led.red;
      nb  <= nb + (net_led.green & net_led.red);
      sk  <= sk + ((module_led.green | module_led.red) != (net_led.green | net_led.red));
      cnt <= cnt + 1;
      if (cnt == N - 1) run <= 1'b0;
    end
  end

  assign hmode = name_of(hg, hr, hb);
  assign nmode = name_of(ng, nr, nb);
  assign skew  = 4'(sk);
endmodule : fsled_observer

/* File: tb_fsled_encoder_top.sv */
// self-checking bench for the status indicator encoder
`timescale 1ns/10ps
module tb_fsled_encoder_top;
  import fsled_pkg::*;
  localparam int unsigned HALF = 4;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  fsled_health_type  health = '0;
  fsled_net_type     net = '0;
  fsled_axi_req_type axi_req = '0;
  fsled_axi_rsp_type axi_rsp;
  fsled_led_type     module_led, net_led;
  logic              irq, obs_valid;
  logic              obs_start = 1'b0;
  logic [5:0]        obs_h, obs_n;
  logic [3:0]        obs_skew;
  int                fails = 0, n_tests = 0, cycles = 0;
  logic [1:0]        q_b[$];
  logic [65:0]       q_r[$];
  logic [15:0]       q_o[$];
  logic [4:0]        htab[6] = '{5'h00, 5'h01, 5'h02, 5'h04, 5'h08, 5'h10};
  logic [6:0]        ntab[9] = '{7'h00, 7'h40, 7'h60, 7'h50, 7'h48, 7'h44, 7'h42, 7'h43, 7'h7F};

  fsled_encoder_top #(.FLASH_HALF(HALF)) fsled_encoder_top_i (.clk(clk), .rst(rst), .health(health),
    .net(net), .axi_req(axi_req), .axi_rsp(axi_rsp), .module_led(module_led), .net_led(net_led), .irq(irq));
  fsled_observer #(.HALF(HALF)) fsled_observer_i (.clk(clk), .module_led(module_led), .net_led(net_led),
    .start(obs_start), .valid(obs_valid), .hmode(obs_h), .nmode(obs_n), .skew(obs_skew));

  // ****************************************************************
  // clock, timeout, result watcher
  // ****************************************************************
  initial begin
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      close_out();
    end
  end

  always @(posedge clk) begin
    if (axi_rsp.bvalid === 1'b1 && axi_req.bready) cmp_resp(axi_rsp.bresp, q_b.pop_front());
    if (axi_rsp.rvalid === 1'b1 && axi_req.rready) cmp_word({axi_rsp.rresp, axi_rsp.rdata}, q_r.pop_front());
    if (obs_valid === 1'b1) cmp_obs({obs_h, obs_n, obs_skew}, q_o.pop_front());
  end

  // ****************************************************************
  // compares and expectations
  // ****************************************************************
  task bad(string msg);
    fails++;
    $display("wrong value at %0t: %s", $time, msg);
  endtask : bad
  task cmp_resp(logic [1:0] got, logic [1:0] e);
    n_tests++;
    if (got !== e) bad("write response");
  endtask : cmp_resp
  task cmp_word(logic [33:0] got, logic [65:0] e);
    n_tests++;
    if ((got[31:0] & e[65:34]) !== (e[31:0] & e[65:34]) || got[33:32] !== e[33:32]) bad("read data");
  endtask : cmp_word
  task cmp_obs(logic [15:0] got, logic [15:0] e);
    n_tests++;
    if (got !== e) bad("indicator pattern");
  endtask : cmp_obs
  task cmp_bit(logic got, logic e);
    n_tests++;
    if (got !== e) bad("interrupt line");
  endtask : cmp_bit

  function automatic logic [5:0] hm(logic [4:0] h);
    if (h[4]) return 6'h20;
    if (h[3]) return 6'h10;
    if (h[2]) return 6'h08;
    if (h[1]) return 6'h04;
    if (h[0]) return 6'h02;
    return 6'h01;
  endfunction : hm
  function automatic logic [5:0] nm(logic [6:0] n);
    if (n[3] || n[2]) return 6'h10;
    if (n[1]) return n[0] ? 6'h20 : 6'h10;
    if (n[4]) return 6'h08;
    if (!n[6]) return 6'h01;
    return n[5] ? 6'h02 : 6'h04;
  endfunction : nm
  // lit class: 0 dark, 1 lit half the time, 2 lit every cycle (alternation never goes dark)
  function automatic int lc(logic [5:0] m);
    return (m == 6'h01) ? 0 : (m == 6'h02 || m == 6'h10 || m == 6'h20) ? 2 : 1;
  endfunction : lc

  // ****************************************************************
  // drivers
  // ****************************************************************
  task tick(int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task wr(logic [4:0] a, logic [31:0] d, logic [3:0] s, logic [1:0] e);
    logic busy;
    busy = 1'b1;
    q_b.push_back(e);
    @(posedge clk);
    axi_req.awaddr  <= a;
    axi_req.awvalid <= 1'b1;
    axi_req.wdata   <= d;
    axi_req.wstrb   <= s;
    axi_req.wvalid  <= 1'b1;
    axi_req.bready  <= 1'b1;
    while (busy) begin
      @(posedge clk);
      if (axi_req.awvalid && axi_rsp.awready) axi_req.awvalid <= 1'b0;
      if (axi_req.wvalid && axi_rsp.wready) axi_req.wvalid <= 1'b0;
      if (axi_rsp.bvalid === 1'b1) begin
        axi_req.bready <= 1'b0;
        busy = 1'b0;
      end
    end
  endtask : wr
  task rd(logic [4:0] a, logic [31:0] d, logic [31:0] m, logic [1:0] e);
    q_r.push_back({m, e, d});
    @(posedge clk);
    axi_req.araddr  <= a;
    axi_req.arvalid <= 1'b1;
    axi_req.rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (axi_req.arvalid && axi_rsp.arready) axi_req.arvalid <= 1'b0;
    end while (axi_rsp.rvalid !== 1'b1);
    axi_req.rready <= 1'b0;
  endtask : rd
  // leds trail the inputs by two edges, so let them settle before the window opens
  task observe(logic [5:0] h, logic [5:0] n);
    int sk;
    sk = (lc(h) == lc(n)) ? 0 : (lc(h) == 1 || lc(n) == 1) ? HALF : 2 * HALF;
    tick(3);
    q_o.push_back({h, n, 4'(sk)});
    obs_start <= 1'b1;
    @(posedge clk);
    obs_start <= 1'b0;
    tick(2 * HALF + 2);
  endtask : observe

  task close_out();
    $display("comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    logic [4:0] hv;
    logic [6:0] nv;
    logic [2:0] re;
    void'($urandom(32'hD083));
    tick(4);
    rst <= 1'b0;
    tick(1);
    rd(OFF_CTRL, 32'h1, 32'hFFFFFFFF, RESP_OKAY);
    rd(OFF_IRQ_EN, 32'h0, 32'hFFFFFFFF, RESP_OKAY);
    rd(OFF_IRQ_CLR, 32'h0, 32'hFFFFFFFF, RESP_OKAY);
    rd(5'h14, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
    wr(OFF_STATUS, 32'h0, 4'hF, RESP_SLVERR);
    rd(OFF_STATUS, 32'h0101, 32'h3F3F, RESP_OKAY);
    $display("test registers done");
    for (int i = 0; i < 14; i++) begin
      hv = (i < 6) ? htab[i] : 5'($urandom);
      nv = (i < 9) ? ntab[i] : 7'($urandom);
      health <= fsled_health_type'(hv);
      net    <= fsled_net_type'(nv);
      observe(hm(hv), nm(nv));
      rd(OFF_STATUS, {18'h0, nm(nv), 2'h0, hm(hv)}, 32'h3F3F, RESP_OKAY);
    end
    $display("test patterns done");
    health <= fsled_health_type'(5'h01);
    net    <= fsled_net_type'(7'h60);
    tick(4);
    wr(OFF_IRQ_CLR, 32'h7, 4'hF, RESP_OKAY);
    wr(OFF_IRQ_EN, 32'h4, 4'hF, RESP_OKAY);
    rd(OFF_IRQ_ST, 32'h0, 32'h7, RESP_OKAY);
    cmp_bit(irq, 1'b0);
    net <= fsled_net_type'(7'h48);
    tick(4);
    rd(OFF_IRQ_ST, 32'h6, 32'h7, RESP_OKAY);
    cmp_bit(irq, 1'b1);
    wr(OFF_IRQ_EN, 32'h0, 4'hF, RESP_OKAY);
    tick(2);
    cmp_bit(irq, 1'b0);
    re = 3'($urandom);
    wr(OFF_IRQ_EN, {29'h0, re}, 4'hF, RESP_OKAY);
    rd(OFF_IRQ_EN, {29'h0, re}, 32'h7, RESP_OKAY);
    tick(2);
    cmp_bit(irq, (re & 3'h6) != 3'h0);
    wr(OFF_IRQ_CLR, 32'h7, 4'hF, RESP_OKAY);
    rd(OFF_IRQ_ST, 32'h0, 32'h7, RESP_OKAY);
    tick(2);
    cmp_bit(irq, 1'b0);
    $display("test interrupt done");
    health <= fsled_health_type'(5'h02);
    net    <= fsled_net_type'(7'h50);
    wr(OFF_CTRL, 32'h0, 4'hF, RESP_OKAY);
    observe(6'h01, 6'h01);
    rd(OFF_STATUS, 32'h0804, 32'h3F3F, RESP_OKAY);
    wr(OFF_CTRL, 32'h1, 4'h0, RESP_OKAY);
    rd(OFF_CTRL, 32'h0, 32'h1, RESP_OKAY);
    wr(OFF_CTRL, 32'h1, 4'hF, RESP_OKAY);
    observe(6'h04, 6'h08);
    $display("test enable done");
    close_out();
  end
endmodule : tb_fsled_encoder_top
